// *** hdl/dflash_seq_pkg.sv ***
package dflash_seq_pkg;
   // ---------------------------------------------------------------
   // widths and array geometry
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned WI_W = 11;
   localparam int unsigned DF_WORDS = 2048;
   localparam logic [17:0] DF_BASE_GADDR = 18'h04000;
   localparam logic [17:0] DF_BYTES = 18'h01000;
   localparam logic [11:0] SECTOR_WORDS = 12'h080;
   localparam logic [15:0] ERASED_WORD = 16'hffff;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] OFF_CONFIG = 4'h0;
   localparam logic [3:0] OFF_ERR_CONFIG = 4'h1;
   localparam logic [3:0] OFF_STATUS = 4'h2;
   localparam logic [3:0] OFF_ERR_STATUS = 4'h3;
   localparam logic [3:0] OFF_PARAM_INDEX = 4'h4;
   localparam logic [3:0] OFF_PARAM_DATA = 4'h5;
   localparam logic [3:0] OFF_PROTECT = 4'h6;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned BIT_COMMAND_COMPLETE_IRQ_ENABLE = 0;
   localparam int unsigned BIT_SINGLE_FAULT_IRQ_ENABLE = 0;
   localparam int unsigned BIT_DOUBLE_FAULT_IRQ_ENABLE = 1;
   localparam int unsigned BIT_COMMAND_COMPLETE_FLAG = 7;
   localparam int unsigned BIT_ACCESS_ERROR_FLAG = 5;
   localparam int unsigned BIT_PROTECTION_VIOLATION_FLAG = 4;
   localparam int unsigned BIT_VERR = 1;
   localparam int unsigned BIT_VUNC = 0;
   localparam int unsigned BIT_SINGLE_FAULT_FLAG = 0;
   localparam int unsigned BIT_DOUBLE_FAULT_FLAG = 1;
   localparam int unsigned BIT_PROT_EN = 15;

   // ---------------------------------------------------------------
   // commands and parameter indices
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
   localparam logic [7:0] CMD_PROGRAM = 8'h11;
   localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
   localparam logic [2:0] IDX_ONE = 3'h1;
   localparam logic [2:0] IDX_TWO = 3'h2;
   localparam logic [2:0] IDX_FIVE = 3'h5;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic RST_COMMAND_COMPLETE_FLAG = 1'b1;
   localparam logic [15:0] RST_PROTECT = 16'h0000;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned PROG_TIME_NS = 20000;
   localparam int unsigned ERASE_TIME_NS = 4000000;
   localparam int unsigned PROG_CYCLES_I = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] PROG_CYCLES = PROG_CYCLES_I[15:0];
   localparam int unsigned ERASE_CYCLES_DEFAULT =
      (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_PROG = 5'b00010,
      ST_ERASE = 5'b00100,
      ST_VREAD = 5'b01000,
      ST_VCHECK = 5'b10000
   } seq_state_type;
endpackage

// *** hdl/flash_array_if.sv ***
`timescale 1ns/1ps
interface flash_array_if;
   logic [10:0] addr;
   logic [15:0] wdata;
   logic we;
   logic re;
   logic [15:0] rdata;
   modport ctrl (output addr, output wdata, output we, output re, input rdata);
   modport mem (input addr, input wdata, input we, input re, output rdata);
endinterface

// *** hdl/flash_array.sv ***
`timescale 1ns/1ps
module flash_array (
   input wire logic sys_clk_in,
   flash_array_if.mem bus
);
   // contents are not reset: an aborted operation leaves them undefined
   logic [15:0] cells_r [0:dflash_seq_pkg::DF_WORDS-1];
   logic [15:0] rdata_r;

   always_ff @(posedge sys_clk_in) begin
      if (bus.we) begin
         cells_r[bus.addr] <= bus.wdata;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (bus.re) begin
         rdata_r <= cells_r[bus.addr];
      end
   end

   assign bus.rdata = rdata_r;
endmodule

// *** hdl/data_flash_command_sequencer.sv ***
`timescale 1ns/1ps
// How it works
// - code 10h: check slot-two count of words from slot-one address read erased.
// - erase-verify launched with slot index other than two sets access error.
// - invalid or odd 18-bit global address sets access error, all commands.
// - erase-verify range running past the block end sets access error.
// - erase-verify read sets verify error on any fault, uncorrectable on hard ones.
// - code 11h programs one to four words; slot index picks the count.
// - program with slot index below two or above five sets access error.
// - program group running past the block end sets access error.
// - protected target on program or erase sets protection flag, array untouched.
// - program and erase are verified afterwards, setting both verify bits likewise.
// - code 12h erases the sector holding the address; index must be one.
// - sector erase writes every word, then verifies erased, then completes.
// - command not permitted in current mode sets access error.
// - completion flag sets again after operation and verify finish.
// - command interrupt is completion flag gated by its enable.
// - error interrupt is either fault flag gated by its own enable.
// - wait mode does not disturb the sequencer; completion interrupt wakes cpu.
// - stop request is acknowledged only after the running command completes.
// - reset aborts any running command immediately; array contents then undefined.
module data_flash_command_sequencer #(
   parameter int unsigned ERASE_CYCLES = dflash_seq_pkg::ERASE_CYCLES_DEFAULT
) (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   input wire logic cmd_allowed_in,
   input wire logic ecc_single_in,
   input wire logic ecc_double_in,
   input wire logic stop_req_in,
   output logic stop_ack_out,
   output logic cmd_irq_out,
   output logic err_irq_out
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [11:0] word_index(input logic [17:0] gaddr);
      logic [17:0] off;
      off = gaddr - dflash_seq_pkg::DF_BASE_GADDR;
      return off[12:1];
   endfunction

   function automatic logic addr_valid(input logic [17:0] gaddr);
      return (gaddr >= dflash_seq_pkg::DF_BASE_GADDR) &&
             (gaddr < dflash_seq_pkg::DF_BASE_GADDR + dflash_seq_pkg::DF_BYTES);
   endfunction

   localparam logic [15:0] ERASE_CNT = ERASE_CYCLES[15:0];
   localparam logic [12:0] WORDS13 = 13'h0800;

   flash_array_if arr ();
   flash_array u_array (
      .sys_clk_in(sys_clk_in),
      .bus(arr)
   );

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   dflash_seq_pkg::seq_state_type state_r;
   logic command_complete_irq_enable_r, single_fault_irq_enable_r, double_fault_irq_enable_r;
   logic command_complete_flag_r, access_error_flag_r, protection_violation_flag_r, verr_r, vunc_r;
   logic single_fault_flag_r, double_fault_flag_r;
   logic [2:0] idx_r;
   logic [15:0] slot_r [0:5];
   logic [15:0] prot_r;
   logic [11:0] cur_r;
   logic [11:0] base_r;
   logic [15:0] rem_r;
   logic [15:0] total_r;
   logic [1:0] sp_r;
   logic [15:0] timer_r;
   logic vprog_r;

   // ---------------------------------------------------------------
   // launch checks
   // ---------------------------------------------------------------
   logic wr_status, launch, acc_err, prot_hit;
   logic [7:0] cmd_code;
   logic [17:0] gaddr;
   logic [11:0] wi, sec_start;
   logic [12:0] span_end;
   logic [2:0] nwords;

   assign wr_status = ce_in && reg_wr_in && (reg_addr_in == dflash_seq_pkg::OFF_STATUS);
   assign launch = wr_status && reg_wdata_in[dflash_seq_pkg::BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag_r;
   assign cmd_code = slot_r[0][15:8];
   assign gaddr = {slot_r[0][1:0], slot_r[1]};
   assign wi = word_index(gaddr);
   assign sec_start = wi & ~(dflash_seq_pkg::SECTOR_WORDS - 12'h001);
   assign nwords = idx_r - 3'h1;

   always_comb begin
      acc_err = 1'b0;
      prot_hit = 1'b0;
      span_end = {1'b0, wi};
      case (cmd_code)
         dflash_seq_pkg::CMD_ERASE_VERIFY: begin
            if (idx_r != dflash_seq_pkg::IDX_TWO) acc_err = 1'b1;
            span_end = {1'b0, wi} + slot_r[2][12:0];
            if (slot_r[2] > 16'h0800 || span_end > WORDS13) acc_err = 1'b1;
         end
         dflash_seq_pkg::CMD_PROGRAM: begin
            if (idx_r < dflash_seq_pkg::IDX_TWO || idx_r > dflash_seq_pkg::IDX_FIVE) begin
               acc_err = 1'b1;
            end
            span_end = {1'b0, wi} + {10'h000, nwords};
            if (span_end > WORDS13) acc_err = 1'b1;
            prot_hit = prot_r[dflash_seq_pkg::BIT_PROT_EN] &&
                       (span_end > {2'b00, prot_r[10:0]});
         end
         dflash_seq_pkg::CMD_ERASE_SECTOR: begin
            if (idx_r != dflash_seq_pkg::IDX_ONE) acc_err = 1'b1;
            span_end = {1'b0, sec_start} + {1'b0, dflash_seq_pkg::SECTOR_WORDS};
            prot_hit = prot_r[dflash_seq_pkg::BIT_PROT_EN] &&
                       (span_end > {2'b00, prot_r[10:0]});
         end
         default: acc_err = 1'b1;
      endcase
      if (!addr_valid(gaddr) || gaddr[0]) acc_err = 1'b1;
      if (!cmd_allowed_in) acc_err = 1'b1;
   end

   logic go;
   assign go = launch && !acc_err && !prot_hit;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   logic last_word, check_bad;
   logic [15:0] expect_word;
   assign last_word = (rem_r == 16'h0001);
   assign expect_word = vprog_r ? slot_r[3'h2 + {1'b0, sp_r}] : dflash_seq_pkg::ERASED_WORD;
   assign check_bad = (arr.rdata != expect_word) || ecc_double_in;

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= dflash_seq_pkg::ST_IDLE;
         cur_r <= 12'h000;
         base_r <= 12'h000;
         rem_r <= 16'h0000;
         total_r <= 16'h0000;
         sp_r <= 2'b00;
         timer_r <= 16'h0000;
         vprog_r <= 1'b0;
      end else if (ce_in) begin
         case (state_r)
            dflash_seq_pkg::ST_IDLE: begin
               if (go) begin
                  cur_r <= (cmd_code == dflash_seq_pkg::CMD_ERASE_SECTOR) ? sec_start : wi;
                  base_r <= (cmd_code == dflash_seq_pkg::CMD_ERASE_SECTOR) ? sec_start : wi;
                  sp_r <= 2'b00;
                  vprog_r <= (cmd_code == dflash_seq_pkg::CMD_PROGRAM);
                  case (cmd_code)
                     dflash_seq_pkg::CMD_PROGRAM: begin
                        rem_r <= {13'h0000, nwords};
                        total_r <= {13'h0000, nwords};
                        timer_r <= dflash_seq_pkg::PROG_CYCLES;
                        state_r <= dflash_seq_pkg::ST_PROG;
                     end
                     dflash_seq_pkg::CMD_ERASE_SECTOR: begin
                        rem_r <= {4'h0, dflash_seq_pkg::SECTOR_WORDS};
                        total_r <= {4'h0, dflash_seq_pkg::SECTOR_WORDS};
                        timer_r <= ERASE_CNT;
                        state_r <= dflash_seq_pkg::ST_ERASE;
                     end
                     default: begin
                        rem_r <= slot_r[2];
                        total_r <= slot_r[2];
                        state_r <= (slot_r[2] == 16'h0000) ? dflash_seq_pkg::ST_IDLE :
                                   dflash_seq_pkg::ST_VREAD;
                     end
                  endcase
               end
            end
            dflash_seq_pkg::ST_PROG: begin
               if (timer_r != 16'h0001) begin
                  timer_r <= timer_r - 16'h0001;
               end else if (last_word) begin
                  cur_r <= base_r;
                  rem_r <= total_r;
                  sp_r <= 2'b00;
                  state_r <= dflash_seq_pkg::ST_VREAD;
               end else begin
                  cur_r <= cur_r + 12'h001;
                  rem_r <= rem_r - 16'h0001;
                  sp_r <= sp_r + 2'b01;
                  timer_r <= dflash_seq_pkg::PROG_CYCLES;
               end
            end
            dflash_seq_pkg::ST_ERASE: begin
               // pulse time first, then one erased word written per cycle
               if (timer_r != 16'h0000) begin
                  timer_r <= timer_r - 16'h0001;
               end else if (last_word) begin
                  cur_r <= base_r;
                  rem_r <= total_r;
                  state_r <= dflash_seq_pkg::ST_VREAD;
               end else begin
                  cur_r <= cur_r + 12'h001;
                  rem_r <= rem_r - 16'h0001;
               end
            end
            dflash_seq_pkg::ST_VREAD: begin
               state_r <= dflash_seq_pkg::ST_VCHECK;
            end
            dflash_seq_pkg::ST_VCHECK: begin
               if (last_word) begin
                  state_r <= dflash_seq_pkg::ST_IDLE;
               end else begin
                  cur_r <= cur_r + 12'h001;
                  rem_r <= rem_r - 16'h0001;
                  sp_r <= sp_r + 2'b01;
                  state_r <= dflash_seq_pkg::ST_VREAD;
               end
            end
            default: state_r <= dflash_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // array port, gated by enable so a frozen block touches nothing
   logic prog_wr, erase_wr;
   assign prog_wr = (state_r == dflash_seq_pkg::ST_PROG) && (timer_r == 16'h0001);
   assign erase_wr = (state_r == dflash_seq_pkg::ST_ERASE) && (timer_r == 16'h0000);
   assign arr.addr = cur_r[10:0];
   assign arr.wdata = prog_wr ? slot_r[3'h2 + {1'b0, sp_r}] : dflash_seq_pkg::ERASED_WORD;
   assign arr.we = ce_in && (prog_wr || erase_wr);
   assign arr.re = ce_in && (state_r == dflash_seq_pkg::ST_VREAD);

   logic vcheck;
   assign vcheck = ce_in && (state_r == dflash_seq_pkg::ST_VCHECK);

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   logic done_now;
   assign done_now = (vcheck && last_word) ||
                     (go && cmd_code == dflash_seq_pkg::CMD_ERASE_VERIFY &&
                      slot_r[2] == 16'h0000);

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         command_complete_flag_r <= dflash_seq_pkg::RST_COMMAND_COMPLETE_FLAG;
      end else if (ce_in) begin
         if (done_now) command_complete_flag_r <= 1'b1;
         else if (go) command_complete_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         access_error_flag_r <= 1'b0;
         protection_violation_flag_r <= 1'b0;
         verr_r <= 1'b0;
         vunc_r <= 1'b0;
      end else if (ce_in) begin
         if (launch) begin
            // a launch starts a fresh error picture
            access_error_flag_r <= acc_err;
            protection_violation_flag_r <= prot_hit;
            verr_r <= 1'b0;
            vunc_r <= 1'b0;
         end else begin
            if (wr_status && reg_wdata_in[dflash_seq_pkg::BIT_ACCESS_ERROR_FLAG]) access_error_flag_r <= 1'b0;
            if (wr_status && reg_wdata_in[dflash_seq_pkg::BIT_PROTECTION_VIOLATION_FLAG]) protection_violation_flag_r <= 1'b0;
            if (vcheck && (check_bad || ecc_single_in)) verr_r <= 1'b1;
            if (vcheck && check_bad) vunc_r <= 1'b1;
         end
      end
   end

   // fault flags: a fault in the clearing cycle survives
   logic wr_err_status;
   assign wr_err_status = ce_in && reg_wr_in && (reg_addr_in == dflash_seq_pkg::OFF_ERR_STATUS);

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         single_fault_flag_r <= 1'b0;
         double_fault_flag_r <= 1'b0;
      end else if (ce_in) begin
         if (vcheck && ecc_single_in) single_fault_flag_r <= 1'b1;
         else if (wr_err_status && reg_wdata_in[dflash_seq_pkg::BIT_SINGLE_FAULT_FLAG]) single_fault_flag_r <= 1'b0;
         if (vcheck && ecc_double_in) double_fault_flag_r <= 1'b1;
         else if (wr_err_status && reg_wdata_in[dflash_seq_pkg::BIT_DOUBLE_FAULT_FLAG]) double_fault_flag_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         command_complete_irq_enable_r <= 1'b0;
         single_fault_irq_enable_r <= 1'b0;
         double_fault_irq_enable_r <= 1'b0;
         idx_r <= 3'h0;
         prot_r <= dflash_seq_pkg::RST_PROTECT;
         for (int i = 0; i < 6; i++) slot_r[i] <= 16'h0000;
      end else if (ce_in && reg_wr_in) begin
         case (reg_addr_in)
            dflash_seq_pkg::OFF_CONFIG: command_complete_irq_enable_r <= reg_wdata_in[dflash_seq_pkg::BIT_COMMAND_COMPLETE_IRQ_ENABLE];
            dflash_seq_pkg::OFF_ERR_CONFIG: begin
               single_fault_irq_enable_r <= reg_wdata_in[dflash_seq_pkg::BIT_SINGLE_FAULT_IRQ_ENABLE];
               double_fault_irq_enable_r <= reg_wdata_in[dflash_seq_pkg::BIT_DOUBLE_FAULT_IRQ_ENABLE];
            end
            // parameters are frozen while a command runs
            dflash_seq_pkg::OFF_PARAM_INDEX: if (command_complete_flag_r) idx_r <= reg_wdata_in[2:0];
            dflash_seq_pkg::OFF_PARAM_DATA: if (command_complete_flag_r && idx_r <= 3'h5) slot_r[idx_r] <= reg_wdata_in;
            dflash_seq_pkg::OFF_PROTECT: if (command_complete_flag_r) prot_r <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      case (reg_addr_in)
         dflash_seq_pkg::OFF_CONFIG: rd_mux[dflash_seq_pkg::BIT_COMMAND_COMPLETE_IRQ_ENABLE] = command_complete_irq_enable_r;
         dflash_seq_pkg::OFF_ERR_CONFIG: begin
            rd_mux[dflash_seq_pkg::BIT_SINGLE_FAULT_IRQ_ENABLE] = single_fault_irq_enable_r;
            rd_mux[dflash_seq_pkg::BIT_DOUBLE_FAULT_IRQ_ENABLE] = double_fault_irq_enable_r;
         end
         dflash_seq_pkg::OFF_STATUS: begin
            rd_mux[dflash_seq_pkg::BIT_COMMAND_COMPLETE_FLAG] = command_complete_flag_r;
            rd_mux[dflash_seq_pkg::BIT_ACCESS_ERROR_FLAG] = access_error_flag_r;
            rd_mux[dflash_seq_pkg::BIT_PROTECTION_VIOLATION_FLAG] = protection_violation_flag_r;
            rd_mux[dflash_seq_pkg::BIT_VERR] = verr_r;
            rd_mux[dflash_seq_pkg::BIT_VUNC] = vunc_r;
         end
         dflash_seq_pkg::OFF_ERR_STATUS: begin
            rd_mux[dflash_seq_pkg::BIT_SINGLE_FAULT_FLAG] = single_fault_flag_r;
            rd_mux[dflash_seq_pkg::BIT_DOUBLE_FAULT_FLAG] = double_fault_flag_r;
         end
         dflash_seq_pkg::OFF_PARAM_INDEX: rd_mux[2:0] = idx_r;
         dflash_seq_pkg::OFF_PARAM_DATA: rd_mux = (idx_r <= 3'h5) ? slot_r[idx_r] : 16'h0000;
         dflash_seq_pkg::OFF_PROTECT: rd_mux = prot_r;
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) reg_rdata_out <= 16'h0000;
      else if (ce_in) reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
   end

   // ---------------------------------------------------------------
   // requests to the cpu
   // ---------------------------------------------------------------
   // no wait input: the sequencer runs the same whether or not the cpu waits
   assign cmd_irq_out = command_complete_flag_r && command_complete_irq_enable_r;
   assign err_irq_out = (double_fault_flag_r && double_fault_irq_enable_r) || (single_fault_flag_r && single_fault_irq_enable_r);
   assign stop_ack_out = stop_req_in && command_complete_flag_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_erase_go;
      go && cmd_code == dflash_seq_pkg::CMD_ERASE_SECTOR;
   endsequence
   sequence s_erase_running;
      state_r == dflash_seq_pkg::ST_ERASE && !command_complete_flag_r;
   endsequence

   AST_EV_INDEX: assert property (launch && cmd_code == dflash_seq_pkg::CMD_ERASE_VERIFY &&
      idx_r != dflash_seq_pkg::IDX_TWO |=> access_error_flag_r && command_complete_flag_r)
      else $error("erase-verify bad index not flagged");
   AST_PROG_INDEX: assert property (launch && cmd_code == dflash_seq_pkg::CMD_PROGRAM &&
      (idx_r < 3'h2 || idx_r > 3'h5) |=> access_error_flag_r)
      else $error("program bad index not flagged");
   AST_ERASE_INDEX: assert property (launch && cmd_code == dflash_seq_pkg::CMD_ERASE_SECTOR &&
      idx_r != dflash_seq_pkg::IDX_ONE |=> access_error_flag_r)
      else $error("erase bad index not flagged");
   AST_MISALIGNED: assert property (launch && gaddr[0] |=> access_error_flag_r)
      else $error("odd address not flagged");
   AST_MODE: assert property (launch && !cmd_allowed_in |=> access_error_flag_r && command_complete_flag_r)
      else $error("disallowed command not flagged");
   AST_BREACH: assert property (launch && cmd_code == dflash_seq_pkg::CMD_ERASE_VERIFY &&
      span_end > WORDS13 |=> access_error_flag_r)
      else $error("section breach not flagged");
   AST_ERR_NO_OP: assert property (launch && (acc_err || prot_hit) |=>
      state_r == dflash_seq_pkg::ST_IDLE && command_complete_flag_r && !arr.we)
      else $error("errored launch ran the array");
   AST_PROT: assert property (launch && prot_hit |=> protection_violation_flag_r)
      else $error("protected target not flagged");
   AST_ERASE_SEQ: assert property (s_erase_go |=> s_erase_running)
      else $error("sector erase did not start");
   AST_DONE: assert property (vcheck && last_word |=> command_complete_flag_r &&
      state_r == dflash_seq_pkg::ST_IDLE)
      else $error("completion flag not set after verify");
   AST_DOUBLE: assert property (vcheck && ecc_double_in |=> verr_r && vunc_r && double_fault_flag_r)
      else $error("double fault not reported");
   AST_STOP: assert property (!command_complete_flag_r |-> !stop_ack_out)
      else $error("stop acknowledged during command");
endmodule

// *** bench/test_data_flash_command_sequencer.sv ***
`timescale 1ns/1ps
module test_data_flash_command_sequencer;
   typedef struct packed {logic [2:0] ix; logic [47:0] s; logic [15:0] st;} row_type;
   logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, ok = 1'h1, es = 1'h0, sr = 1'h0;
   logic ed = 1'h0;
   logic ack, cirq, eirq;
   logic [3:0] a = 4'h0;
   logic [15:0] wd = 16'h0, q;
   int n_errors = 0, n_checks = 0, cyc = 0;
   row_type rows [12] = '{
      '{3'h1, 48'h120040000000, 16'h80}, // array is not reset, so erase first
      '{3'h2, 48'h100040000004, 16'h80},
      '{3'h2, 48'h110040001234, 16'h80},
      '{3'h2, 48'h100040000001, 16'h83}, // programmed word no longer erased
      '{3'h3, 48'h100040000001, 16'ha0},
      '{3'h1, 48'h110040025555, 16'ha0},
      '{3'h6, 48'h110040025555, 16'ha0},
      '{3'h2, 48'h120040000000, 16'ha0},
      '{3'h2, 48'h110040015555, 16'ha0},
      '{3'h2, 48'h10004ffe0002, 16'ha0},
      '{3'h3, 48'h11004ffe5555, 16'ha0},
      '{3'h2, 48'h130040000001, 16'ha0}}; // unknown command code
   // short erase keeps the run brief
   data_flash_command_sequencer #(.ERASE_CYCLES(10)) dut (.sys_clk_in(clk), .resetn_in(rst_n),
      .ce_in(1'h1), .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(q), .cmd_allowed_in(ok), .ecc_single_in(es), .ecc_double_in(ed),
      .stop_req_in(sr), .stop_ack_out(ack), .cmd_irq_out(cirq), .err_irq_out(eirq));
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop;
      end
   end
   task chk(input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task bus(input logic w, input logic [3:0] ad, input logic [15:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      a <= ad;
      wd <= d;
      @(posedge clk);
      wr <= 1'h0;
      rd <= 1'h0;
      #1;
      if (!w) chk(q, d);
   endtask
   task load(input logic [2:0] ix, input logic [47:0] s);
      for (int k = 0; k < 3; k++) begin
         bus(1'h1, 4'h4, 16'(k));
         bus(1'h1, 4'h5, s[47-16*k -: 16]);
      end
      bus(1'h1, 4'h4, {13'h0, ix});
      bus(1'h1, 4'h2, 16'h80);
   endtask
   task run(input logic [2:0] ix, input logic [47:0] s, input logic [15:0] st);
      load(ix, s);
      for (int i = 0; i < 3000 && cirq !== 1'h1; i++) @(negedge clk);
      chk({15'h0, cirq}, 16'h1);
      bus(1'h0, 4'h2, st);
   endtask
   task report_and_stop;
      if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      bus(1'h1, 4'h0, 16'h1);
      foreach (rows[i]) run(rows[i].ix, rows[i].s, rows[i].st);
      bus(1'h1, 4'h6, 16'h8000);
      run(3'h1, 48'h120040000000, 16'h90);
      run(3'h2, 48'h100040000001, 16'h83); // word survives the refused erase
      bus(1'h1, 4'h6, 16'h0);
      ok <= 1'h0;
      run(3'h2, 48'h100040020001, 16'ha0);
      ok <= 1'h1;
      bus(1'h1, 4'h1, 16'h1);
      es <= 1'h1;
      run(3'h2, 48'h100040020001, 16'h82);
      es <= 1'h0;
      chk({15'h0, eirq}, 16'h1);
      bus(1'h0, 4'h3, 16'h1);
      bus(1'h1, 4'h3, 16'h1);
      chk({15'h0, eirq}, 16'h0);
      bus(1'h1, 4'h1, 16'h3);
      ed <= 1'h1;
      run(3'h2, 48'h110040040abc, 16'h83); // double fault in program verify
      ed <= 1'h0;
      chk({15'h0, eirq}, 16'h1);
      bus(1'h0, 4'h3, 16'h2);
      sr <= 1'h1;
      load(3'h1, 48'h120040000000);
      chk({14'h0, cirq, ack}, 16'h0); // stop held off while busy
      rst_n <= 1'h0;
      @(posedge clk);
      rst_n <= 1'h1;
      #1;
      chk({14'h0, cirq, ack}, 16'h1); // enable cleared by reset
      bus(1'h0, 4'h2, 16'h80);
      report_and_stop;
   end
endmodule
